// ### dv/rx_port_io_gpio_regs_test.sv
`timescale 1ns/100ps
module rx_port_io_gpio_regs_test
  import rx_port_io_regs_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  reg_req_t req = '0;
  logic [1:0] lock = 2'h0;
  logic det = 1'b0;
  logic [6:0] gin = 7'h00;
  logic [7:0] rdata;
  logic rvalid, lock_out, sel_hv;
  logic [1:0] port_en, mode, gout, goe;
  logic [6:0] in_en;
  int errors = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h60;
  // ***********************************************************
  // reference model state
  // ***********************************************************
  logic [1:0] m_lock, m_en, m_mode;
  logic m_hv, m_ovr;
  logic [3:0] m_low;
  logic [6:0] m_in;
  logic [7:0] m_pin [2];

  rx_port_io_gpio_regs dut_u (.CLK(clk), .RESET(reset), .REG_REQ(req),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .PORT_LOCK(lock),
    .LOCK_OUT(lock_out), .PORT_EN(port_en), .IO_DETECT_3V3(det),
    .IO_SEL_HIGH_V(sel_hv), .IO_SUPPLY_MODE(mode), .GPIO_IN(gin),
    .GPIO_INPUT_EN(in_en), .GPIO_OUT(gout), .GPIO_OE(goe));

  // clock at 125 MHz
  always #4 clk = ~clk;

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand

  // expected routed lock from mode and enables
  function automatic logic exp_lock();
    logic [1:0] e;
    e = lock & m_en;
    case (m_lock)
      2'h0: return lock[0];
      2'h1: return lock[1];
      2'h2: return |e;
      default: return (m_en != 2'h0) && (e == m_en);
    endcase
  endfunction : exp_lock

  // expected readback of one address
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    logic [1:0] md;
    md = m_ovr ? m_mode : {2{det}};
    case (a)
      OFS_PORT_CTL: return {4'h8, m_lock, m_en};
      OFS_IO_SUPPLY_CONTROL: return {m_ovr ? m_hv : det, m_ovr, md, m_low};
      OFS_PIN_STS: return {1'b0, gin};
      OFS_IN_CTL: return {1'b0, m_in};
      OFS_PIN0_CTL: return m_pin[0];
      OFS_PIN1_CTL: return m_pin[1];
      default: return 8'h00;
    endcase
  endfunction : exp_rd

  // level driven on a pin from its control byte
  function automatic logic pin_lvl(input logic [7:0] p);
    return (p[4:2] == 3'h4 && p[7:5] == 3'h0) ? p[1] : 1'b0;
  endfunction : pin_lvl

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ***********************************************************
  // register access
  // ***********************************************************
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d,
                        input logic loc);
    // output enable only with input path off
    if ((a == OFS_PIN0_CTL || a == OFS_PIN1_CTL) && m_in[a[0]])
      d[0] = 1'b0;
    if (a == OFS_IN_CTL)
      d[1:0] = d[1:0] & ~{m_pin[1][0], m_pin[0][0]};
    req.addr = a;
    req.wdata = d;
    req.local_src = loc;
    req.wr = 1'b1;
    @(posedge clk);
    #1 req.wr = 1'b0;
    case (a)
      OFS_PORT_CTL: begin
        // routing field from local controller only
        if (loc)
          m_lock = d[3:2];
        m_en = d[1:0];
      end
      OFS_IO_SUPPLY_CONTROL: {m_hv, m_ovr, m_mode, m_low} = d;
      OFS_IN_CTL: m_in = d[6:0];
      OFS_PIN0_CTL: m_pin[0] = d;
      OFS_PIN1_CTL: m_pin[1] = d;
      default: ;
    endcase
    // one idle cycle so a following write raises the strobe afresh
    @(posedge clk);
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    req.addr = a;
    req.rd = 1'b1;
    @(posedge clk);
    #1;
    // valid and data stand for the cycle after the read edge
    chk({7'h0, rvalid}, 8'h01);
    chk(rdata, exp_rd(a));
    req.rd = 1'b0;
    @(posedge clk);
    #1;
    chk({7'h0, rvalid}, 8'h00);
  endtask : reg_rd

  // settle outputs, compare pins, then read every address
  task automatic check_all();
    logic [7:0] e;
    repeat (2) @(posedge clk);
    #1;
    e = exp_rd(OFS_IO_SUPPLY_CONTROL);
    chk({4'h0, lock_out, sel_hv, mode}, {4'h0, exp_lock(), e[7], e[5:4]});
    chk({port_en, 6'h0}, {m_en, 6'h0});
    chk({1'b0, in_en}, {1'b0, m_in});
    chk({4'h0, gout, goe}, {4'h0, pin_lvl(m_pin[1]), pin_lvl(m_pin[0]),
        m_pin[1][0], m_pin[0][0]});
    for (int a = 8'h0b; a <= 8'h12; a++)
      reg_rd(a[7:0]);
  endtask : check_all

  task automatic do_reset();
    reset = 1'b1;
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    m_lock = 2'h0;
    m_en = 2'h3;
    {m_hv, m_ovr, m_mode, m_low} = 8'h09;
    m_in = 7'h7f;
    m_pin[0] = 8'h00;
    m_pin[1] = 8'h00;
    check_all();
  endtask : do_reset

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // ***********************************************************
  // scenarios
  // ***********************************************************
  initial begin
    do_reset();
    // every lock mode against every enable pair
    for (int i = 0; i < 16; i++) begin
      reg_wr(OFS_PORT_CTL, {4'h0, i[3:0]}, 1'b1);
      lock = 2'(next_rand());
      check_all();
    end
    // routing write from another path is dropped
    reg_wr(OFS_PORT_CTL, 8'h03, 1'b0);
    check_all();
    // register-driven pin levels
    reg_wr(OFS_IN_CTL, 8'h7c, 1'b1);
    reg_wr(OFS_PIN0_CTL, 8'h13, 1'b1);
    reg_wr(OFS_PIN1_CTL, 8'h11, 1'b1);
    check_all();
    // random traffic, unmapped neighbours included
    for (int n = 0; n < 150; n++) begin
      reg_wr(8'(8'h0b + next_rand() % 8), 8'(next_rand()),
             1'(next_rand() % 2));
      lock = 2'(next_rand());
      det = 1'(next_rand());
      gin = 7'(next_rand());
      check_all();
      if (n == 75)
        do_reset();
    end
    give_verdict();
  end

  // watchdog well beyond the expected run length
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
endmodule : rx_port_io_gpio_regs_test

// ### src/rx_port_io_gpio_regs.sv
`timescale 1ns/100ps
module rx_port_io_gpio_regs
  import rx_port_io_regs_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire reg_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic [1:0] PORT_LOCK,
  output logic LOCK_OUT,
  output logic [1:0] PORT_EN,
  input wire logic IO_DETECT_3V3,
  output logic IO_SEL_HIGH_V,
  output logic [1:0] IO_SUPPLY_MODE,
  input wire logic [6:0] GPIO_IN,
  output logic [6:0] GPIO_INPUT_EN,
  output logic [1:0] GPIO_OUT,
  output logic [1:0] GPIO_OE
);

  // ***********************************************************
  // helpers
  // ***********************************************************
  // level driven on a pin from its control byte
  function automatic logic pin_drive(input logic [7:0] ctl);
    logic [2:0] src;
    logic [2:0] sel;
    src = ctl[OUT_SRC_LSB +: 3];
    sel = ctl[OUT_SEL_LSB +: 3];
    pin_drive = (src == SRC_REGISTER) && (sel == SEL_REGISTER) &&
                ctl[OUT_LVL_BIT];
  endfunction : pin_drive

  // ***********************************************************
  // state
  // ***********************************************************
  logic [1:0] lock_sel_reg, lock_sel_next;
  logic [1:0] port_en_reg, port_en_next;
  logic highv_reg, highv_next;
  logic ovr_reg, ovr_next;
  logic [1:0] mode_reg, mode_next;
  logic [3:0] io_low_reg, io_low_next;
  logic [6:0] in_en_reg, in_en_next;
  logic [7:0] pin0_reg, pin0_next;
  logic [7:0] pin1_reg, pin1_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic lock_reg, lock_next;
  logic sel_out_reg, sel_out_next;
  logic [1:0] mode_out_reg, mode_out_next;
  logic [1:0] gpio_out_reg, gpio_out_next;
  logic [1:0] gpio_oe_reg, gpio_oe_next;
  logic eff_highv;
  logic [1:0] eff_mode;
  logic [1:0] det_mode;

  // ***********************************************************
  // register writes
  // ***********************************************************
  always_comb begin
    lock_sel_next = lock_sel_reg;
    port_en_next = port_en_reg;
    highv_next = highv_reg;
    ovr_next = ovr_reg;
    mode_next = mode_reg;
    io_low_next = io_low_reg;
    in_en_next = in_en_reg;
    pin0_next = pin0_reg;
    pin1_next = pin1_reg;
    if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        OFS_PORT_CTL: begin
          if (REG_REQ.local_src) begin
            lock_sel_next = REG_REQ.wdata[LOCK_SEL_LSB +: 2];
          end
          port_en_next[1] = REG_REQ.wdata[PORT1_BIT];
          port_en_next[0] = REG_REQ.wdata[PORT0_BIT];
        end
        OFS_IO_SUPPLY_CONTROL: begin
          highv_next = REG_REQ.wdata[HIGHV_BIT];
          ovr_next = REG_REQ.wdata[OVR_BIT];
          mode_next = REG_REQ.wdata[MODE_LSB +: 2];
          io_low_next = REG_REQ.wdata[3:0];
        end
        OFS_IN_CTL: in_en_next = REG_REQ.wdata[6:0];
        OFS_PIN0_CTL: pin0_next = REG_REQ.wdata;
        OFS_PIN1_CTL: pin1_next = REG_REQ.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      lock_sel_reg <= LOCK_SEL_RST;
      port_en_reg <= PORT_EN_RST;
      highv_reg <= IO_HIGHV_RST;
      ovr_reg <= IO_OVR_RST;
      mode_reg <= IO_MODE_RST;
      io_low_reg <= IO_LOW_RST;
      in_en_reg <= IN_EN_RST;
      pin0_reg <= PIN_CTL_RST;
      pin1_reg <= PIN_CTL_RST;
    end else begin
      lock_sel_reg <= lock_sel_next;
      port_en_reg <= port_en_next;
      highv_reg <= highv_next;
      ovr_reg <= ovr_next;
      mode_reg <= mode_next;
      io_low_reg <= io_low_next;
      in_en_reg <= in_en_next;
      pin0_reg <= pin0_next;
      pin1_reg <= pin1_next;
    end
  end

  // ***********************************************************
  // supply selection
  // ***********************************************************
  // detected level as mode code
  assign det_mode = IO_DETECT_3V3 ? MODE_3V3 : MODE_1V8;
  assign eff_highv = ovr_reg ? highv_reg : IO_DETECT_3V3;
  assign eff_mode = ovr_reg ? mode_reg : det_mode;

  // ***********************************************************
  // read path and pin outputs
  // ***********************************************************
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = REG_REQ.rd;
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        OFS_PORT_CTL: rdata_next = {PORT_CTL_TOP_RST, 2'h0,
                                    lock_sel_reg, port_en_reg};
        OFS_IO_SUPPLY_CONTROL: rdata_next = {eff_highv, ovr_reg, eff_mode,
                                  io_low_reg};
        OFS_PIN_STS: rdata_next = {1'b0, GPIO_IN};
        OFS_IN_CTL: rdata_next = {1'b0, in_en_reg};
        OFS_PIN0_CTL: rdata_next = pin0_reg;
        OFS_PIN1_CTL: rdata_next = pin1_reg;
        default: rdata_next = 8'h00;
      endcase
    end
    case (lock_mode_t'(lock_sel_reg))
      LOCK_PORT0: lock_next = PORT_LOCK[0];
      LOCK_PORT1: lock_next = PORT_LOCK[1];
      LOCK_ANY: lock_next = |(PORT_LOCK & port_en_reg);
      LOCK_ALL: lock_next = (|port_en_reg) &&
                            (&(PORT_LOCK | ~port_en_reg));
      default: lock_next = 1'b0;
    endcase
    sel_out_next = eff_highv;
    mode_out_next = eff_mode;
    gpio_out_next = {pin_drive(pin1_reg), pin_drive(pin0_reg)};
    gpio_oe_next = {pin1_reg[OUT_EN_BIT], pin0_reg[OUT_EN_BIT]};
  end

  // output flops
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      lock_reg <= 1'b0;
      sel_out_reg <= IO_HIGHV_RST;
      mode_out_reg <= IO_MODE_RST;
      gpio_out_reg <= 2'h0;
      gpio_oe_reg <= 2'h0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      lock_reg <= lock_next;
      sel_out_reg <= sel_out_next;
      mode_out_reg <= mode_out_next;
      gpio_out_reg <= gpio_out_next;
      gpio_oe_reg <= gpio_oe_next;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign REG_RVALID = rvalid_reg;
  assign LOCK_OUT = lock_reg;
  assign PORT_EN = port_en_reg;
  assign IO_SEL_HIGH_V = sel_out_reg;
  assign IO_SUPPLY_MODE = mode_out_reg;
  assign GPIO_INPUT_EN = in_en_reg;
  assign GPIO_OUT = gpio_out_reg;
  assign GPIO_OE = gpio_oe_reg;

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_lock_port0:
    assert property ((lock_sel_reg == 2'h0) |=>
                     (LOCK_OUT == $past(PORT_LOCK[0])))
    else $error("lock output not following port 0");

  a_lock_all:
    assert property ((lock_sel_reg == 2'h3) && (port_en_reg == 2'h3) &&
                     (PORT_LOCK != 2'h3) |=> !LOCK_OUT)
    else $error("lock output high without both ports locked");

  a_remote_lock_wr:
    assert property (REG_REQ.wr && !REG_REQ.local_src &&
                     (REG_REQ.addr == OFS_PORT_CTL) |=> $stable(lock_sel_reg))
    else $error("remote write changed lock routing");

  a_port1_write:
    assert property (REG_REQ.wr && (REG_REQ.addr == OFS_PORT_CTL) |=>
                     (PORT_EN[1] == $past(REG_REQ.wdata[1])))
    else $error("second port enable not written");

  a_port0_write:
    assert property (REG_REQ.wr && (REG_REQ.addr == OFS_PORT_CTL) |=>
                     (PORT_EN[0] == $past(REG_REQ.wdata[0])))
    else $error("first port enable not written");

  a_detect_read:
    assert property (REG_REQ.rd && (REG_REQ.addr == OFS_IO_SUPPLY_CONTROL) && !ovr_reg
                     |=> (REG_RDATA[7] == $past(IO_DETECT_3V3)) &&
                     (REG_RDATA[5:4] == {2{$past(IO_DETECT_3V3)}}))
    else $error("io read not showing detected level");

  a_supply_detect:
    assert property (!ovr_reg |=>
                     (IO_SUPPLY_MODE == {2{$past(IO_DETECT_3V3)}}))
    else $error("supply mode not from detection");

  a_status_read:
    assert property (REG_REQ.rd && (REG_REQ.addr == OFS_PIN_STS) |=>
                     REG_RVALID && (REG_RDATA == {1'b0, $past(GPIO_IN)}))
    else $error("pin status read wrong");

  a_input_en:
    assert property (REG_REQ.wr && (REG_REQ.addr == OFS_IN_CTL) |=>
                     (GPIO_INPUT_EN == $past(REG_REQ.wdata[6:0])))
    else $error("input enables not written");

  // driver enable two cycles after write
  a_oe_follow:
    assert property (REG_REQ.wr && (REG_REQ.addr == OFS_PIN0_CTL) |=> ##1
                     (GPIO_OE[0] == $past(REG_REQ.wdata[0], 2)))
    else $error("pin 0 driver enable late or wrong");

  a_src_other:
    assert property ((pin1_reg[4:2] != 3'h4) |=> !GPIO_OUT[1])
    else $error("pin 1 driven from unsupported source");

  a_reg_level:
    assert property ((pin0_reg[7:2] == 6'h04) |=>
                     (GPIO_OUT[0] == $past(pin0_reg[1])))
    else $error("pin 0 not driving register level");

  a_lock_any:
    assert property ((lock_sel_reg == 2'h2) &&
                     ((PORT_LOCK & port_en_reg) == 2'h0) |=> !LOCK_OUT)
    else $error("lock output high without an enabled port locked");

  a_port_readback:
    assert property (REG_REQ.rd && (REG_REQ.addr == OFS_PORT_CTL) |=>
                     (REG_RDATA[1:0] == $past(port_en_reg)))
    else $error("port enables not read back");

  a_supply_override:
    assert property (ovr_reg |=> (IO_SEL_HIGH_V == $past(highv_reg)) &&
                     (IO_SUPPLY_MODE == $past(mode_reg)))
    else $error("supply controls not from written values");

  // pin 1 driver enable two cycles after write
  a_pin1_oe_follow:
    assert property (REG_REQ.wr && (REG_REQ.addr == OFS_PIN1_CTL) |=> ##1
                     (GPIO_OE[1] == $past(REG_REQ.wdata[0], 2)))
    else $error("pin 1 driver enable late or wrong");

  c_lock_any: cover property ((lock_sel_reg == 2'h2) && LOCK_OUT);
  c_lock_all: cover property ((lock_sel_reg == 2'h3) && LOCK_OUT);
  c_override: cover property (ovr_reg && IO_SEL_HIGH_V);
  c_pin_high: cover property (GPIO_OE[0] && GPIO_OUT[0]);
  c_remote_wr: cover property (REG_REQ.wr && !REG_REQ.local_src);

endmodule : rx_port_io_gpio_regs

// ### src/rx_port_io_regs_pkg.sv
// Notes on behaviour
// - lock routing bits 3:2 pick port0, port1, any enabled or all enabled
// - lock routing writes accepted only from a local I2C controller
// - control bit 1 enables the second receiver port, resets enabled
// - control bit 0 enables the first receiver port, resets enabled
// - io bit 7 selects 1.8V or 3.3V for I2C and interrupt pins, resets 0
// - without override, reads of voltage select and supply mode show detection
// - override bit 6 picks detected level or written values for supply controls
// - supply mode 00 means 1.8V, 11 means 3.3V, others reserved
// - pin status bits 6:0 show live pin levels, bit 7 reads zero
// - input control bit n enables pin n input path, all reset enabled
// - pin control bit 0 enables the output driver, resets disabled
// - pin control holds source in bits 4:2 and select in bits 7:5
// - source 100 with select 000 drives the pin from pin control bit 1
package rx_port_io_regs_pkg;

  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [7:0] OFS_PORT_CTL = 8'h0c;
  localparam logic [7:0] OFS_IO_SUPPLY_CONTROL = 8'h0d;
  localparam logic [7:0] OFS_PIN_STS = 8'h0e;
  localparam logic [7:0] OFS_IN_CTL = 8'h0f;
  localparam logic [7:0] OFS_PIN0_CTL = 8'h10;
  localparam logic [7:0] OFS_PIN1_CTL = 8'h11;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int LOCK_SEL_LSB = 2;
  localparam int PORT1_BIT = 1;
  localparam int PORT0_BIT = 0;
  localparam int HIGHV_BIT = 7;
  localparam int OVR_BIT = 6;
  localparam int MODE_LSB = 4;
  localparam int OUT_SEL_LSB = 5;
  localparam int OUT_SRC_LSB = 2;
  localparam int OUT_LVL_BIT = 1;
  localparam int OUT_EN_BIT = 0;

  // ***********************************************************
  // reset values and codes
  // ***********************************************************
  localparam logic [1:0] LOCK_SEL_RST = 2'h0;
  localparam logic [1:0] PORT_EN_RST = 2'h3;
  localparam logic [1:0] PORT_CTL_TOP_RST = 2'h2;
  localparam logic IO_HIGHV_RST = 1'h0;
  localparam logic IO_OVR_RST = 1'h0;
  localparam logic [1:0] IO_MODE_RST = 2'h0;
  localparam logic [3:0] IO_LOW_RST = 4'h9;
  localparam logic [6:0] IN_EN_RST = 7'h7f;
  localparam logic [7:0] PIN_CTL_RST = 8'h00;
  localparam logic [1:0] MODE_1V8 = 2'h0;
  localparam logic [1:0] MODE_3V3 = 2'h3;
  localparam logic [2:0] SRC_REGISTER = 3'h4;
  localparam logic [2:0] SEL_REGISTER = 3'h0;

  // lock routing modes
  typedef enum logic [1:0] {
    LOCK_PORT0 = 2'h0,
    LOCK_PORT1 = 2'h1,
    LOCK_ANY = 2'h2,
    LOCK_ALL = 2'h3
  } lock_mode_t;

  // register access request from the I2C target
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic local_src;
  } reg_req_t;

endpackage : rx_port_io_regs_pkg
